// ==== hw/arc_result_bank.sv ====
`timescale 1ns/100ps
// How it works
// - Input bus voltage result, 16-bit unsigned, 1 mV steps, at 35h, zero at reset.
// - First adapter voltage result, 16-bit unsigned, 1 mV steps, at 37h, zero at reset.
// - Second adapter voltage result, 16-bit unsigned, 1 mV steps, at 39h, zero at reset.
// - Battery sense voltage result, 16-bit unsigned, 1 mV steps, at 3Bh, zero at reset.
// - System rail voltage result, 16-bit unsigned, 1 mV steps, at 3Dh, zero at reset.
// - Thermistor ratio result, 16-bit percentage, 0.0976563% steps, at 3Fh, zero at reset.
// - Die temperature, 16-bit two's complement, 0.5 C steps, at 41h, zero at reset.
module arc_result_bank
  import arc_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic en_i,
  // Converter results
  input wire arc_upd_t upd_i,
  // Register port
  input wire arc_req_t req_i,
  output arc_rsp_t rsp_o
);

  // ****************************************************************
  // Result storage
  // ****************************************************************
  logic [ARC_NCH-1:0][15:0] res;

  // One slot per channel, loaded only by the converter
  genvar gi;
  generate
    for (gi = 0; gi < ARC_NCH; gi++) begin : g_slot
      arc_result_slot u_slot (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .en_i(en_i),
        .ld_i(upd_i.valid && (upd_i.chan == arc_chan_t'(gi))),
        .value_i(upd_i.value),
        .value_o(res[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // Read decode
  // ****************************************************************
  typedef struct packed {
    arc_rsp_t rsp;
  } arc_bank_st_t;

  arc_bank_st_t st_r;
  arc_bank_st_t st_nxt;
  logic [7:0] rd_byte;

  // Byte select; write requests never reach the slots
  always_comb begin
    rd_byte = ARC_UNMAPPED_DATA;
    for (int i = 0; i < ARC_NCH; i++) begin
      if (req_i.addr == ARC_OFS_TABLE[i]) begin
        rd_byte = res[i][ARC_HI_MSB:ARC_HI_LSB];
      end else if (req_i.addr == ARC_OFS_TABLE[i] + ARC_OFS_LO_STEP) begin
        rd_byte = res[i][ARC_LO_MSB:ARC_LO_LSB];
      end
    end
  end

  // Answer one cycle after the read; write strobe is ignored on purpose
  always_comb begin
    st_nxt = st_r;
    st_nxt.rsp.valid = req_i.rd;
    if (req_i.rd) begin
      st_nxt.rsp.data = rd_byte;
    end
  end

  // Data holds until the next read so a slow reader can sample it late
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      st_r.rsp <= '0;
    end else if (en_i) begin
      st_r <= st_nxt;
    end
  end

  assign rsp_o = st_r.rsp;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_bus_hi;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      en_i && req_i.rd && req_i.addr == ARC_OFS_INPUT_BUS_VOLTAGE
      |=> rsp_o.valid && rsp_o.data == $past(res[0][15:8]);
  endproperty
  a_bus_hi: assert property (p_bus_hi) else $error("bus voltage high byte wrong");

  property p_ad1_lo;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      en_i && req_i.rd && req_i.addr == ARC_OFS_ADAPTER_ONE_VOLTAGE + ARC_OFS_LO_STEP
      |=> rsp_o.data == $past(res[1][7:0]);
  endproperty
  a_ad1_lo: assert property (p_ad1_lo) else $error("adapter one low byte wrong");

  property p_ad2_hi;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      en_i && req_i.rd && req_i.addr == ARC_OFS_ADAPTER_TWO_VOLTAGE
      |=> rsp_o.data == $past(res[2][15:8]);
  endproperty
  a_ad2_hi: assert property (p_ad2_hi) else $error("adapter two high byte wrong");

  property p_bat_load;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      en_i && upd_i.valid && upd_i.chan == ARC_CH_BATTERY_SENSE_VOLTAGE
      |=> res[3] == $past(upd_i.value);
  endproperty
  a_bat_load: assert property (p_bat_load) else $error("battery result not loaded");

  property p_sys_lo;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      en_i && req_i.rd && req_i.addr == ARC_OFS_SYSTEM_RAIL_VOLTAGE + ARC_OFS_LO_STEP
      |=> rsp_o.data == $past(res[4][7:0]);
  endproperty
  a_sys_lo: assert property (p_sys_lo) else $error("system rail low byte wrong");

  property p_ts_hi;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      en_i && req_i.rd && req_i.addr == ARC_OFS_THERMISTOR_RATIO
      |=> rsp_o.data == $past(res[5][15:8]);
  endproperty
  a_ts_hi: assert property (p_ts_hi) else $error("thermistor high byte wrong");

  property p_die_rd;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      en_i && req_i.rd && req_i.addr == ARC_OFS_DIE_TEMPERATURE
      ##1 en_i && req_i.rd && req_i.addr == ARC_OFS_DIE_TEMPERATURE + ARC_OFS_LO_STEP
      |=> rsp_o.data == $past(res[6][7:0]) && $past(rsp_o.data) == $past(res[6][15:8], 2);
  endproperty
  a_die_rd: assert property (p_die_rd) else $error("die temperature pair wrong");

  property p_wr_ignored;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      req_i.wr && !upd_i.valid |=> $stable(res);
  endproperty
  a_wr_ignored: assert property (p_wr_ignored) else $error("write changed a result");

  property p_reset_zero;
    @(posedge clk_sys_i)
      !rst_b_i |=> res == '0 && !rsp_o.valid && rsp_o.data == 8'h00;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("reset did not clear bank");

  property p_unmapped;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      en_i && req_i.rd
      && (req_i.addr < ARC_OFS_INPUT_BUS_VOLTAGE || req_i.addr > ARC_OFS_DIE_TEMPERATURE + ARC_OFS_LO_STEP)
      |=> rsp_o.data == ARC_UNMAPPED_DATA;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_freeze;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      !en_i |=> $stable(res) && $stable(rsp_o);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while disabled");

  property p_bus_lo;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      en_i && req_i.rd && req_i.addr == ARC_OFS_INPUT_BUS_VOLTAGE + ARC_OFS_LO_STEP
      |=> rsp_o.valid && rsp_o.data == $past(res[0][7:0]);
  endproperty
  a_bus_lo: assert property (p_bus_lo) else $error("bus voltage low byte wrong");

  property p_ad1_hi;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      en_i && req_i.rd && req_i.addr == ARC_OFS_ADAPTER_ONE_VOLTAGE
      |=> rsp_o.valid && rsp_o.data == $past(res[1][15:8]);
  endproperty
  a_ad1_hi: assert property (p_ad1_hi) else $error("adapter one high byte wrong");

  property p_ad2_lo;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      en_i && req_i.rd && req_i.addr == ARC_OFS_ADAPTER_TWO_VOLTAGE + ARC_OFS_LO_STEP
      |=> rsp_o.valid && rsp_o.data == $past(res[2][7:0]);
  endproperty
  a_ad2_lo: assert property (p_ad2_lo) else $error("adapter two low byte wrong");

  property p_bat_hi;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      en_i && req_i.rd && req_i.addr == ARC_OFS_BATTERY_SENSE_VOLTAGE
      |=> rsp_o.valid && rsp_o.data == $past(res[3][15:8]);
  endproperty
  a_bat_hi: assert property (p_bat_hi) else $error("battery high byte wrong");

  property p_sys_hi;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      en_i && req_i.rd && req_i.addr == ARC_OFS_SYSTEM_RAIL_VOLTAGE
      |=> rsp_o.valid && rsp_o.data == $past(res[4][15:8]);
  endproperty
  a_sys_hi: assert property (p_sys_hi) else $error("system rail high byte wrong");

  property p_ts_lo;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      en_i && req_i.rd && req_i.addr == ARC_OFS_THERMISTOR_RATIO + ARC_OFS_LO_STEP
      |=> rsp_o.valid && rsp_o.data == $past(res[5][7:0]);
  endproperty
  a_ts_lo: assert property (p_ts_lo) else $error("thermistor low byte wrong");

  property p_die_load;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      en_i && upd_i.valid && upd_i.chan == ARC_CH_DIE_TEMPERATURE
      |=> res[6] == $past(upd_i.value);
  endproperty
  a_die_load: assert property (p_die_load) else $error("die temperature not loaded");

  // Valid marks accepted reads only, so a host never takes a stale byte
  property p_valid_only_rd;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      en_i && !req_i.rd |=> !rsp_o.valid;
  endproperty
  a_valid_only_rd: assert property (p_valid_only_rd) else $error("answer without a read");

  property p_data_hold;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      en_i && !req_i.rd |=> $stable(rsp_o.data);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("read data moved without a read");

  // Channel code 7 names no slot and must leave every result alone
  property p_stray_chan;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      en_i && upd_i.valid && upd_i.chan == 3'h7 |=> $stable(res);
  endproperty
  a_stray_chan: assert property (p_stray_chan) else $error("stray channel changed a result");

  // Main scenarios
  c_update_then_read: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    en_i && upd_i.valid ##1 en_i && req_i.rd);
  c_write_attempt: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i) en_i && req_i.wr);
  c_die_pair: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    req_i.rd && req_i.addr == ARC_OFS_DIE_TEMPERATURE
    ##1 req_i.rd && req_i.addr == ARC_OFS_DIE_TEMPERATURE + ARC_OFS_LO_STEP);
  c_frozen_read: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i) !en_i && req_i.rd);

endmodule : arc_result_bank

// ==== hw/arc_pkg.sv ====
package arc_pkg;

  // ****************************************************************
  // Widths and channel count
  // ****************************************************************
  localparam int ARC_ADDR_W = 8;
  localparam int ARC_BYTE_W = 8;
  localparam int ARC_RES_W = 16;
  localparam int ARC_NCH = 7;
  localparam int ARC_CH_W = 3;

  // ****************************************************************
  // Register offsets: high byte at the offset, low byte at offset + 1
  // ****************************************************************
  localparam logic [7:0] ARC_OFS_INPUT_BUS_VOLTAGE = 8'h35;
  localparam logic [7:0] ARC_OFS_ADAPTER_ONE_VOLTAGE = 8'h37;
  localparam logic [7:0] ARC_OFS_ADAPTER_TWO_VOLTAGE = 8'h39;
  localparam logic [7:0] ARC_OFS_BATTERY_SENSE_VOLTAGE = 8'h3b;
  localparam logic [7:0] ARC_OFS_SYSTEM_RAIL_VOLTAGE = 8'h3d;
  localparam logic [7:0] ARC_OFS_THERMISTOR_RATIO = 8'h3f;
  localparam logic [7:0] ARC_OFS_DIE_TEMPERATURE = 8'h41;
  localparam logic [7:0] ARC_OFS_LO_STEP = 8'h01;

  // Offsets indexed by channel number
  localparam logic [ARC_NCH-1:0][7:0] ARC_OFS_TABLE = {
    ARC_OFS_DIE_TEMPERATURE, ARC_OFS_THERMISTOR_RATIO, ARC_OFS_SYSTEM_RAIL_VOLTAGE,
    ARC_OFS_BATTERY_SENSE_VOLTAGE, ARC_OFS_ADAPTER_TWO_VOLTAGE, ARC_OFS_ADAPTER_ONE_VOLTAGE,
    ARC_OFS_INPUT_BUS_VOLTAGE};

  // ****************************************************************
  // Field layout and reset values
  // ****************************************************************
  localparam int ARC_HI_MSB = 15;
  localparam int ARC_HI_LSB = 8;
  localparam int ARC_LO_MSB = 7;
  localparam int ARC_LO_LSB = 0;
  localparam logic [15:0] ARC_RES_RESET = 16'h0000;
  localparam logic [7:0] ARC_UNMAPPED_DATA = 8'h00;

  // ****************************************************************
  // Channel numbering
  // ****************************************************************
  typedef enum logic [2:0] {
    ARC_CH_INPUT_BUS_VOLTAGE,
    ARC_CH_ADAPTER_ONE_VOLTAGE,
    ARC_CH_ADAPTER_TWO_VOLTAGE,
    ARC_CH_BATTERY_SENSE_VOLTAGE,
    ARC_CH_SYSTEM_RAIL_VOLTAGE,
    ARC_CH_THERMISTOR_RATIO,
    ARC_CH_DIE_TEMPERATURE
  } arc_chan_t;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  // New conversion result from the converter
  typedef struct packed {
    logic valid;
    arc_chan_t chan;
    logic [15:0] value;
  } arc_upd_t;

  // Register port request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } arc_req_t;

  // Register port answer
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } arc_rsp_t;

endpackage : arc_pkg

// ==== hw/arc_result_slot.sv ====
`timescale 1ns/100ps
module arc_result_slot
  import arc_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic en_i,
  // Load from converter
  input wire logic ld_i,
  input wire logic [15:0] value_i,
  // Stored result
  output logic [15:0] value_o
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [15:0] value;
  } arc_slot_st_t;

  arc_slot_st_t st_r;
  arc_slot_st_t st_nxt;

  // Only the converter may change the value; the host has no path here
  always_comb begin
    st_nxt = st_r;
    if (ld_i) begin
      st_nxt.value = value_i;
    end
  end

  // Cleared to zero at reset, frozen while the enable is low
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      st_r.value <= ARC_RES_RESET;
    end else if (en_i) begin
      st_r <= st_nxt;
    end
  end

  assign value_o = st_r.value;

endmodule : arc_result_slot

// ==== verification/arc_host_model.sv ====
`timescale 1ns/100ps
module arc_host_model
  import arc_pkg::*;
(
  // Clock
  input wire logic clk_sys_i,
  // Register port towards the bank
  output arc_req_t req_o,
  input wire arc_rsp_t rsp_i
);
  // ****************************************************************
  // Host side of the register port
  // ****************************************************************
  initial req_o = '0;

  // Released lines show the inverse, so a stale address never looks valid
  task automatic read_byte(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    int n;
    @(posedge clk_sys_i);
    req_o <= '{rd: 1'b1, wr: 1'b0, addr: addr, wdata: ~addr};
    @(posedge clk_sys_i);
    req_o <= '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: addr};
    ok = 1'b0;
    data = 8'h00;
    // Answer stands one cycle only, so look at every low phase
    for (n = 0; n < 4; n++) begin
      @(negedge clk_sys_i);
      if (rsp_i.valid === 1'b1) begin
        data = rsp_i.data;
        ok = 1'b1;
        break;
      end
    end
  endtask : read_byte

  // High then low on consecutive edges, the spacing that keeps a tear window short
  task automatic read_pair(input logic [7:0] addr, output logic [15:0] data, output logic ok);
    @(posedge clk_sys_i);
    req_o <= '{rd: 1'b1, wr: 1'b0, addr: addr, wdata: ~addr};
    @(posedge clk_sys_i);
    req_o <= '{rd: 1'b1, wr: 1'b0, addr: addr + ARC_OFS_LO_STEP, wdata: addr};
    @(negedge clk_sys_i);
    ok = (rsp_i.valid === 1'b1);
    data[15:8] = rsp_i.data;
    @(posedge clk_sys_i);
    req_o <= '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: addr};
    @(negedge clk_sys_i);
    ok = ok && (rsp_i.valid === 1'b1);
    data[7:0] = rsp_i.data;
  endtask : read_pair

  // Single write cycle, no answer expected
  task automatic write_byte(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk_sys_i);
    req_o <= '{rd: 1'b0, wr: 1'b1, addr: addr, wdata: data};
    @(posedge clk_sys_i);
    req_o <= '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~data};
  endtask : write_byte
endmodule : arc_host_model

// ==== verification/tb_top.sv ====
`timescale 1ns/100ps
module tb_top
  import arc_pkg::*;
;
  logic clk_sys_i;
  logic rst_b_i;
  logic en_i;
  arc_upd_t upd;
  arc_req_t req;
  arc_rsp_t rsp;
  int failures;
  int comparisons;
  // Boundary values: range tops, thermistor full scale, negative die temperature
  logic [15:0] vals [ARC_NCH] = '{16'h7530, 16'h0abc, 16'h1357, 16'h4e20, 16'h5dc0, 16'h03ff, 16'hffb0};

  arc_result_bank dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .en_i(en_i), .upd_i(upd), .req_i(req), .rsp_o(rsp));
  arc_host_model host (.clk_sys_i(clk_sys_i), .req_o(req), .rsp_i(rsp));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // High byte at the offset, low byte one above
  task automatic rd16(input logic [7:0] ofs, input logic [15:0] exp);
    logic [7:0] d;
    logic ok;
    host.read_byte(ofs, d, ok);
    if (!ok) begin
      failures++;
      summarize();
    end
    chk(d, exp[15:8]);
    host.read_byte(ofs + ARC_OFS_LO_STEP, d, ok);
    if (!ok) begin
      failures++;
      summarize();
    end
    chk(d, exp[7:0]);
  endtask : rd16

  task automatic upd_word(input int ch, input logic [15:0] v);
    @(posedge clk_sys_i);
    upd <= '{valid: 1'b1, chan: arc_chan_t'(ch), value: v};
    @(posedge clk_sys_i);
    upd.valid <= 1'b0;
  endtask : upd_word

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset_values();
    for (int i = 0; i < ARC_NCH; i++) begin
      rd16(ARC_OFS_TABLE[i], ARC_RES_RESET);
    end
    $display("test reset_values done");
  endtask : t_reset_values

  // Each high-byte read is sampled two edges after its load, with one idle cycle between
  task automatic t_load_values();
    for (int i = 0; i < ARC_NCH; i++) begin
      upd_word(i, vals[i]);
      rd16(ARC_OFS_TABLE[i], vals[i]);
    end
    $display("test load_values done");
  endtask : t_load_values

  // Writes to both bytes, a stray channel code, then an unmapped read
  task automatic t_writes_ignored();
    logic [7:0] d;
    logic ok;
    for (int i = 0; i < ARC_NCH; i++) begin
      host.write_byte(ARC_OFS_TABLE[i], 8'hff);
      host.write_byte(ARC_OFS_TABLE[i] + ARC_OFS_LO_STEP, 8'h00);
    end
    upd_word(7, 16'h1111);
    for (int i = 0; i < ARC_NCH; i++) begin
      rd16(ARC_OFS_TABLE[i], vals[i]);
    end
    host.read_byte(8'h43, d, ok);
    chk({7'h00, ok}, 8'h01);
    chk(d, ARC_UNMAPPED_DATA);
    $display("test writes_ignored done");
  endtask : t_writes_ignored

  // A converter strobe or a read while disabled must not land
  task automatic t_enable_freeze();
    logic [7:0] d;
    logic ok;
    @(posedge clk_sys_i);
    en_i <= 1'b0;
    upd_word(0, 16'h0001);
    host.read_byte(ARC_OFS_TABLE[0], d, ok);
    chk({7'h00, ok}, 8'h00);
    @(posedge clk_sys_i);
    en_i <= 1'b1;
    rd16(ARC_OFS_TABLE[0], vals[0]);
    $display("test enable_freeze done");
  endtask : t_enable_freeze

  // Back-to-back high and low reads of every result
  task automatic t_read_pair();
    logic [15:0] w;
    logic ok;
    for (int i = 0; i < ARC_NCH; i++) begin
      host.read_pair(ARC_OFS_TABLE[i], w, ok);
      chk({7'h00, ok}, 8'h01);
      chk(w[15:8], vals[i][15:8]);
      chk(w[7:0], vals[i][7:0]);
    end
    $display("test read_pair done");
  endtask : t_read_pair

  task automatic t_mid_reset();
    @(posedge clk_sys_i);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    t_reset_values();
    $display("test mid_reset done");
  endtask : t_mid_reset

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    failures = 0;
    comparisons = 0;
    rst_b_i = 1'b0;
    en_i = 1'b1;
    upd = '0;
    repeat (10) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    t_reset_values();
    t_load_values();
    t_writes_ignored();
    t_read_pair();
    t_enable_freeze();
    t_mid_reset();
    summarize();
  end
endmodule : tb_top
